/* vdc_dispatch_stall_control.sv */
/*
  Front end and issue flow control of the signal-processor core: fetch
  phases, dispatch of issue groups, idle insertion, branch redirect and
  memory stalls across the whole pipeline.
  Assumes separate program and data memories with ready lines, and an
  external decoder that reports the branch, load and idle content of the
  group standing in execute stage one.
*/
//
// How it works
// - fetch eight words as one group
// - group splits into one to eight issue groups
// - dispatch scans parallel flags for group ends
// - stall so each issue group dispatches alone
// - fetch phases hold, no new address meanwhile
// - new fetch address generated every free cycle
// - each instruction finishes after fixed stages
// - idle op carries an optional cycle count
// - extra idle cycles leave earlier groups running
// - next group waits out the idle period
// - ending branch slots override running idle
// - program and data memories kept apart
// - fetch: generate, send, wait, receive, dispatch
// - load: address, send, access, receive, write
// - memory not ready stalls at wait or stage three
// - memory stall freezes every phase
// - stalls add cycles, never change results
// - branch in stage one starts target address
`timescale 1ns/1ps

module vdc_dispatch_stall_control
  import vdc_pkg::*;
#(
  parameter int GROUP_WORDS = `VDC_GROUP_WORDS,
  parameter int WORD_BITS = `VDC_WORD_BITS,
  parameter logic [`VDC_WORD_BITS-1:0] RESET_PC = `VDC_RESET_PC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // program memory side
  output logic pmem_req,
  output logic [WORD_BITS-1:0] pmem_addr,
  input wire logic pmem_ready,
  input wire logic [GROUP_WORDS*WORD_BITS-1:0] pmem_rdata,
  // data memory side
  output logic dmem_req,
  input wire logic dmem_ready,
  // content of the group in execute stage one
  input wire logic e1_is_load,
  input wire logic e1_is_branch,
  input wire logic [WORD_BITS-1:0] e1_branch_target,
  input wire logic [`VDC_IDLE_CNT_W-1:0] e1_idle_count,
  // issue group towards the functional units
  output logic issue_valid,
  output logic [GROUP_WORDS-1:0] issue_mask,
  output logic [GROUP_WORDS*WORD_BITS-1:0] issue_words,
  output logic decode_valid,
  output logic [GROUP_WORDS-1:0] decode_mask,
  output logic [`VDC_EXEC_LATER-1:0] exec_later_valid,
  output logic load_writeback,
  // stall status
  output logic dispatch_stall,
  output logic memory_stall,
  output logic idle_active
);

  // ========================================================
  // parameter check
  generate
    if (GROUP_WORDS != `VDC_GROUP_WORDS ||
        WORD_BITS != `VDC_WORD_BITS) begin : g_bad_geometry
      $error("vdc: group geometry must match the shared state layout");
    end
  endgenerate

  vdc_state_t s_reg;
  vdc_state_t s_next;

  logic [GROUP_WORDS-1:0] dp_pbits;
  logic [GROUP_WORDS-1:0] dp_mask;
  logic [`VDC_IDX_W-1:0] dp_end;
  logic dp_last;
  logic dp_busy;
  logic pw_stall;
  logic ld_stall;
  logic hold_all;
  logic br_expire;
  logic dc_adv;
  logic dp_go;
  logic fe_adv;
  logic e1_branch_now;
  logic idle_load;
  logic idle_busy;
  logic idle_end;
  logic idle_start;
  logic [WORD_BITS-1:0] pg_addr;

  // ========================================================
  // parallel flag of every slot of the dispatched group
  genvar g;
  generate
    for (g = 0; g < GROUP_WORDS; g++) begin : g_pbit
      assign dp_pbits[g] = s_reg.dp_words[g*WORD_BITS + `VDC_PBIT];
    end
  endgenerate

  // ========================================================
  // issue group boundary finder
  vdc_group_scan u_scan (
    .pbits(dp_pbits),
    .start(s_reg.dp_start),
    .mask(dp_mask),
    .end_idx(dp_end),
    .last(dp_last)
  );

  // ========================================================
  // multicycle idle counter
  vdc_idle_counter u_idle (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(idle_load),
    .count(e1_idle_count),
    .hold(hold_all),
    .clear(br_expire),
    .busy(idle_busy),
    .ending(idle_end)
  );

  // ========================================================
  // stall sources and advance conditions
  assign pw_stall = s_reg.pw_v && !pmem_ready;
  assign ld_stall = s_reg.ex_v[`VDC_EX_STAGE3] &&
                    s_reg.ex_ld[`VDC_EX_STAGE3] && !dmem_ready;
  assign hold_all = pw_stall || ld_stall;
  assign dp_busy = (s_reg.dp_st != VDC_DISP_EMPTY);
  // target about to reach stage one: branch beats the idle
  assign br_expire = !hold_all &&
                     (s_reg.br_cnt == `VDC_BR_LAST_SLOT);
  // an idle group in stage one blocks the next group at once
  assign idle_start = s_reg.iss_v && (e1_idle_count > `VDC_IDLE_ONE);
  assign dc_adv = br_expire ||
                  ((!idle_busy || idle_end) && !idle_start);
  assign dp_go = dp_busy && !hold_all &&
                 (!s_reg.dc_v || dc_adv);
  // one combined hold for the fetch phases
  assign fe_adv = !hold_all &&
                  (!dp_busy || (dp_go && dp_last));
  assign e1_branch_now = s_reg.iss_v && e1_is_branch && !hold_all;
  assign idle_load = s_reg.iss_v && !hold_all;
  // address generation: branch target wins the same cycle
  assign pg_addr = e1_branch_now ? e1_branch_target : s_reg.pc;

  // ========================================================
  // next state
  always_comb begin
    s_next = s_reg;

    // fetch phases move as one unit per group
    if (fe_adv) begin
      s_next.pc = pg_addr + `VDC_FG_STEP;
      s_next.ps_v = 1'b1;
      s_next.ps_addr = pg_addr;
      s_next.pw_v = s_reg.ps_v;
      s_next.pr_v = s_reg.pw_v;
      if (s_reg.pw_v) begin
        s_next.pr_words = pmem_rdata;
      end
    end else if (e1_branch_now) begin
      // redirect remembered while the front end is held
      s_next.pc = e1_branch_target;
    end

    // dispatch slot, one issue group per cycle
    case (s_reg.dp_st)
      VDC_DISP_EMPTY: begin
        if (fe_adv && s_reg.pr_v) begin
          s_next.dp_st = VDC_DISP_FIRST;
          s_next.dp_words = s_reg.pr_words;
          s_next.dp_start = '0;
        end
      end
      VDC_DISP_FIRST, VDC_DISP_SPLIT: begin
        if (dp_go && dp_last) begin
          if (s_reg.pr_v) begin
            s_next.dp_st = VDC_DISP_FIRST;
            s_next.dp_words = s_reg.pr_words;
          end else begin
            s_next.dp_st = VDC_DISP_EMPTY;
          end
          s_next.dp_start = '0;
        end else if (dp_go) begin
          // more groups left: fetch phases stay held
          s_next.dp_st = VDC_DISP_SPLIT;
          s_next.dp_start = dp_end + `VDC_IDX_ONE;
        end
      end
      default: begin
        s_next.dp_st = VDC_DISP_EMPTY;
        s_next.dp_start = '0;
      end
    endcase

    // decode stage takes the dispatched group
    if (dp_go) begin
      s_next.dc_v = 1'b1;
      s_next.dc_words = s_reg.dp_words;
      s_next.dc_mask = dp_mask;
    end else if (!hold_all && dc_adv) begin
      s_next.dc_v = 1'b0;
    end

    // execute stage one, bubbles while idle runs
    if (!hold_all) begin
      s_next.iss_v = s_reg.dc_v && dc_adv;
      s_next.iss_words = s_reg.dc_words;
      s_next.iss_mask = s_reg.dc_mask;
    end

    // later execute stages: fixed shift, frozen on stall
    if (!hold_all) begin
      s_next.ex_v = {s_reg.ex_v[`VDC_EXEC_LATER-2:0], s_reg.iss_v};
      s_next.ex_ld = {s_reg.ex_ld[`VDC_EXEC_LATER-2:0],
                      s_reg.iss_v && e1_is_load};
    end

    // branch delay slot count, held by memory stalls
    if (e1_branch_now) begin
      s_next.br_cnt = `VDC_BR_DELAY_SLOTS;
    end else if (!hold_all && s_reg.br_cnt != '0) begin
      s_next.br_cnt = s_reg.br_cnt - `VDC_IDX_ONE;
    end
  end

  // ========================================================
  // state register; a hold only repeats the state, nothing is lost
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.pc <= RESET_PC;
      s_reg.dp_st <= VDC_DISP_EMPTY;
    end else begin
      s_reg <= s_next;
    end
  end

  // ========================================================
  // program memory: address sent from the send phase register
  assign pmem_req = s_reg.ps_v;
  assign pmem_addr = s_reg.ps_addr;

  // ========================================================
  // data memory: load address goes out in stage two
  assign dmem_req = s_reg.ex_v[`VDC_EX_STAGE2] &&
                    s_reg.ex_ld[`VDC_EX_STAGE2];
  assign load_writeback = s_reg.ex_v[`VDC_EX_STAGE5] &&
                          s_reg.ex_ld[`VDC_EX_STAGE5];

  // ========================================================
  // issue and status outputs
  assign issue_valid = s_reg.iss_v;
  assign issue_mask = s_reg.iss_mask;
  assign issue_words = s_reg.iss_words;
  assign decode_valid = s_reg.dc_v;
  assign decode_mask = s_reg.dc_mask;
  assign exec_later_valid = s_reg.ex_v;
  assign dispatch_stall = dp_busy && !dp_last;
  assign memory_stall = hold_all;
  assign idle_active = idle_busy;

endmodule // vdc_dispatch_stall_control

/* vdc_params.svh */
/*
  Constants for the dispatch and stall control: group geometry, field
  positions, delay counts and reset values.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef VDC_PARAMS_SVH
`define VDC_PARAMS_SVH

// ==========================================================
// fetch group geometry
`define VDC_GROUP_WORDS 8
`define VDC_WORD_BITS 32
`define VDC_GROUP_BITS 256
`define VDC_IDX_W 3
`define VDC_LAST_IDX 3'h7
`define VDC_IDX_ONE 3'h1
`define VDC_FG_STEP 32'h0000_0020
`define VDC_RESET_PC 32'h0000_0000

// ==========================================================
// instruction fields
`define VDC_PBIT 0

// ==========================================================
// execute pipeline and timing counts
`define VDC_EXEC_LATER 4
`define VDC_EX_STAGE2 0
`define VDC_EX_STAGE3 1
`define VDC_EX_STAGE5 3
`define VDC_BR_DELAY_SLOTS 3'h5
`define VDC_BR_LAST_SLOT 3'h1
`define VDC_IDLE_CNT_W 4
`define VDC_IDLE_ONE 4'h1

`endif

/* vdc_pkg.sv */
/*
  Types shared by the dispatch and stall control modules.
  Assumes vdc_params.svh is on the include path.
*/
`include "vdc_params.svh"

package vdc_pkg;

  // ========================================================
  // dispatch slot state, one-hot
  typedef enum logic [2:0] {
    VDC_DISP_EMPTY = 3'b001,
    VDC_DISP_FIRST = 3'b010,
    VDC_DISP_SPLIT = 3'b100
  } vdc_dp_t;

  // ========================================================
  // whole state of the control top
  typedef struct packed {
    logic [`VDC_WORD_BITS-1:0] pc;
    logic ps_v;
    logic [`VDC_WORD_BITS-1:0] ps_addr;
    logic pw_v;
    logic pr_v;
    logic [`VDC_GROUP_BITS-1:0] pr_words;
    vdc_dp_t dp_st;
    logic [`VDC_GROUP_BITS-1:0] dp_words;
    logic [`VDC_IDX_W-1:0] dp_start;
    logic dc_v;
    logic [`VDC_GROUP_BITS-1:0] dc_words;
    logic [`VDC_GROUP_WORDS-1:0] dc_mask;
    logic iss_v;
    logic [`VDC_GROUP_BITS-1:0] iss_words;
    logic [`VDC_GROUP_WORDS-1:0] iss_mask;
    logic [`VDC_EXEC_LATER-1:0] ex_v;
    logic [`VDC_EXEC_LATER-1:0] ex_ld;
    logic [`VDC_IDX_W-1:0] br_cnt;
  } vdc_state_t;

  // ========================================================
  // idle counter state
  typedef struct packed {
    logic [`VDC_IDLE_CNT_W-1:0] left;
  } vdc_idle_t;

endpackage

/* vdc_group_scan.sv */
/*
  Parallel flag scan of one fetch group: from a start slot, finds where
  the current issue group ends and whether it is the last one.
  Assumes the caller holds the start slot stable while it dispatches.
*/
`timescale 1ns/1ps

module vdc_group_scan
  import vdc_pkg::*;
(
  input wire logic [`VDC_GROUP_WORDS-1:0] pbits,
  input wire logic [`VDC_IDX_W-1:0] start,
  output logic [`VDC_GROUP_WORDS-1:0] mask,
  output logic [`VDC_IDX_W-1:0] end_idx,
  output logic last
);

  // ========================================================
  // membership: slot i belongs if no clear flag lies in [start, i)
  genvar i;
  generate
    for (i = 0; i < `VDC_GROUP_WORDS; i++) begin : g_slot
      always_comb begin
        logic open;
        open = 1'b1;
        for (int j = 0; j < i; j++) begin
          if (j >= start && !pbits[j]) begin
            open = 1'b0;
          end
        end
        mask[i] = (i >= start) && open;
      end
    end
  endgenerate

  // ========================================================
  // highest member slot is the group end
  always_comb begin
    end_idx = start;
    for (int k = 0; k < `VDC_GROUP_WORDS; k++) begin
      if (mask[k]) begin
        end_idx = k[`VDC_IDX_W-1:0];
      end
    end
    last = (end_idx == `VDC_LAST_IDX);
  end

endmodule // vdc_group_scan

/* vdc_idle_counter.sv */
/*
  Multicycle idle counter: counts the extra idle cycles of an idle
  operand and blocks the next issue group while any remain.
  Assumes load is a one-cycle pulse when a group enters execute.
*/
`timescale 1ns/1ps

module vdc_idle_counter
  import vdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [`VDC_IDLE_CNT_W-1:0] count,
  input wire logic hold,
  input wire logic clear,
  output logic busy,
  output logic ending
);

  vdc_idle_t s_reg;
  vdc_idle_t s_next;

  // ========================================================
  // next count: clear beats load beats countdown
  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.left = '0;
    end else if (hold) begin
      s_next = s_reg;
    end else if (load && count > `VDC_IDLE_ONE) begin
      s_next.left = count - `VDC_IDLE_ONE;
    end else if (s_reg.left != '0) begin
      s_next.left = s_reg.left - `VDC_IDLE_ONE;
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = (s_reg.left != '0);
  // last idle cycle: the next group may move up behind it
  assign ending = (s_reg.left == `VDC_IDLE_ONE);

endmodule // vdc_idle_counter

/* vdc_assertions.sv */
/* assertion checker on the top ports of the dispatch and stall control
   assumes it is bound to the top module from the bench top file */
`timescale 1ns/1ps
`include "vdc_params.svh"
module vdc_assertions
  import vdc_pkg::*;
#(
  parameter int GROUP_WORDS = 8,
  parameter int WORD_BITS = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pmem_req,
  input wire logic [WORD_BITS-1:0] pmem_addr,
  input wire logic pmem_ready,
  input wire logic dmem_req,
  input wire logic dmem_ready,
  input wire logic e1_is_load,
  input wire logic e1_is_branch,
  input wire logic [WORD_BITS-1:0] e1_branch_target,
  input wire logic [`VDC_IDLE_CNT_W-1:0] e1_idle_count,
  input wire logic issue_valid,
  input wire logic decode_valid,
  input wire logic [`VDC_EXEC_LATER-1:0] exec_later_valid,
  input wire logic load_writeback,
  input wire logic dispatch_stall,
  input wire logic memory_stall,
  input wire logic idle_active
);
  logic hold;
  logic br;
  // any stall source, and a branch standing in stage one
  assign hold = dispatch_stall | memory_stall | idle_active |
                (issue_valid & (e1_idle_count > 4'h1));
  assign br = issue_valid & e1_is_branch;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ==========
  // stalls
  stall_cause_a:
  assert property (memory_stall |-> !pmem_ready || !dmem_ready)
    else $error("memory stall without a not-ready memory");
  freeze_a:
  assert property (memory_stall |=> $stable(pmem_addr) &&
    $stable(exec_later_valid) && $stable(issue_valid))
    else $error("pipeline moved during a memory stall");
  hold_addr_a:
  assert property (dispatch_stall |=> $stable(pmem_addr))
    else $error("fetch address moved during dispatch stall");
  split_go_a:
  assert property (dispatch_stall && !memory_stall && !idle_active
    |=> decode_valid)
    else $error("next issue group not in decode");

  // ==========
  // fetch flow and branch
  step_a:
  assert property (pmem_req && !hold && !br && !$past(hold) && !$past(br)
    |=> pmem_addr == $past(pmem_addr) + 32'h20)
    else $error("fetch address did not step by one group");
  target_a:
  assert property (br && !hold |=> pmem_addr == $past(e1_branch_target))
    else $error("branch target not fetched next");

  // ==========
  // idle and execute stages
  idle_a:
  assert property (issue_valid && !memory_stall && !e1_is_branch &&
    e1_idle_count > 4'h1 |=> idle_active && !issue_valid)
    else $error("group issued during idle period");
  idle_two_a:
  assert property (issue_valid && !memory_stall && !e1_is_branch &&
    e1_idle_count == 4'h2 ##1 !memory_stall |=> !idle_active)
    else $error("two cycle idle lasted too long");
  load_req_a:
  assert property (issue_valid && e1_is_load && !memory_stall |=> dmem_req)
    else $error("load address not sent in stage two");
  load_wb_a:
  assert property (dmem_req && !memory_stall ##1 !memory_stall [*2]
    |=> load_writeback)
    else $error("load data not written in stage five");
  exec_a:
  assert property (!memory_stall |=>
    exec_later_valid[3:1] == $past(exec_later_valid[2:0]))
    else $error("execute stages did not advance");
endmodule // vdc_assertions

/* vdc_mem_model.sv */
/* program and data memory model for the dispatch and stall control
   assumes split and slow change only while the core is in reset */
`timescale 1ns/1ps
module vdc_mem_model
  import vdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pmem_req,
  input wire logic [31:0] pmem_addr,
  output logic pmem_ready,
  output logic [255:0] pmem_rdata,
  input wire logic dmem_req,
  output logic dmem_ready,
  input wire logic split,
  input wire logic slow
);
  logic [31:0] last_reg;
  logic [31:0] wa_reg;
  logic [31:0] wa;
  logic [1:0] cnt_reg;
  logic [7:0] pb;

  // ==========
  // program memory
  // group in wait phase: the address before the one now sent
  assign wa = (pmem_addr != last_reg) ? last_reg : wa_reg;
  assign pb = split ? wa[12:5] : 8'hFF;
  always_ff @(posedge core_clk) begin
    cnt_reg <= rst_b ? cnt_reg + 2'h1 : 2'h0;
    if (!rst_b || pmem_addr != last_reg) begin
      wa_reg <= last_reg;
      last_reg <= pmem_addr;
    end
  end
  // eight words a group, inverted while no address is sent
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pmem_rdata[32*i +: 32] = {wa[30:5], i[2:0], 2'h0, pb[i]};
      if (!pmem_req) pmem_rdata[32*i +: 32] = ~pmem_rdata[32*i +: 32];
    end
  end
  // separate ready lines, slow mode drops them in turn
  assign pmem_ready = !slow || cnt_reg[0];
  assign dmem_ready = !slow || cnt_reg[1];
endmodule // vdc_mem_model

/* vdc_dispatch_stall_control_test.sv */
/* self-checking bench for the dispatch and stall control
   assumes package, memory model and checker are compiled first */
`timescale 1ns/1ps
module vdc_dispatch_stall_control_test;
  import vdc_pkg::*;
  typedef struct {
    logic [7:0] m;
    logic [255:0] w;
    int gap;
  } vdc_exp_t;
  logic core_clk = 0;
  logic rst_b = 0;
  logic split = 0;
  logic slow = 0;
  logic e1_is_load = 0;
  logic e1_is_branch = 0;
  logic [31:0] e1_branch_target = 0;
  logic [3:0] e1_idle_count = 0;
  logic [31:0] lf = 32'h2BB3;
  logic pmem_req, pmem_ready, dmem_req, dmem_ready, issue_valid;
  logic decode_valid, load_writeback, dispatch_stall, memory_stall;
  logic idle_active;
  logic [31:0] pmem_addr;
  logic [255:0] pmem_rdata, issue_words;
  logic [7:0] issue_mask, decode_mask;
  logic [3:0] exec_later_valid;
  int n_errors = 0, tests_run = 0, nidx = 0, since = 0;
  int idle_k, idle_n, br_k;
  vdc_exp_t exp_q[$];
  vdc_exp_t e;

  always #2.5 core_clk = ~core_clk;

  vdc_dispatch_stall_control uut (.core_clk, .rst_b, .pmem_req,
    .pmem_addr, .pmem_ready, .pmem_rdata, .dmem_req, .dmem_ready,
    .e1_is_load, .e1_is_branch, .e1_branch_target, .e1_idle_count,
    .issue_valid, .issue_mask, .issue_words, .decode_valid, .decode_mask,
    .exec_later_valid, .load_writeback, .dispatch_stall, .memory_stall,
    .idle_active);
  vdc_mem_model mem (.core_clk, .rst_b, .pmem_req, .pmem_addr,
    .pmem_ready, .pmem_rdata, .dmem_req, .dmem_ready, .split, .slow);

  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [255:0] wm(input logic [7:0] m);
    for (int i = 0; i < 8; i++) wm[32*i +: 32] = {32{m[i]}};
  endfunction
  task automatic chk(input string s, input logic [255:0] x, y);
    tests_run++;
    if (x !== y) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, x, y);
    end
  endtask
  // note the issue groups of one fetch group, first carries the gap
  task automatic add_fg(input logic [31:0] a, input int gap);
    logic [7:0] pb;
    vdc_exp_t x;
    pb = split ? a[12:5] : 8'hFF;
    x = '{8'h0, 256'h0, gap};
    for (int i = 0; i < 8; i++) begin
      x.m[i] = 1'b1;
      x.w[32*i +: 32] = {a[30:5], i[2:0], 2'h0, pb[i]};
      if (!pb[i] || i == 7) begin
        exp_q.push_back(x);
        x = '{8'h0, 256'h0, 0};
      end
    end
  endtask

  // ==========
  // drivers and monitor
  // decoder inputs off the falling edge
  always @(negedge core_clk) begin
    lf = lfsr(lf);
    e1_is_load = lf[0];
    e1_idle_count = (nidx == idle_k) ? idle_n[3:0] : {3'h0, lf[1]};
    e1_is_branch = (nidx == br_k);
    e1_branch_target = (nidx == br_k) ? 32'h0000_4000 : lf;
  end
  // each issued group against the oldest note
  always @(posedge core_clk) begin
    since++;
    if (rst_b && issue_valid === 1'b1 && memory_stall === 1'b0 &&
        exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("mask", e.m, issue_mask);
      chk("words", e.w, issue_words & wm(e.m));
      if (e.gap > 0) chk("gap", e.gap, since);
      since = 0;
      nidx++;
    end
  end

  // one run from reset over nfg fetch groups
  task automatic run(input logic sp, sl, input int ik, in, bk, nfg);
    int a;
    rst_b = 1'b0;
    split = sp;
    slow = sl;
    idle_k = ik;
    idle_n = in;
    br_k = bk;
    exp_q.delete();
    repeat (5) @(negedge core_clk);
    nidx = 0;
    for (int g = 0; g < nfg; g++) begin
      a = (g <= bk + 5) ? 32 * g : 16384 + 32 * (g - bk - 6);
      add_fg(a, (g == ik + 1) ? in : (g > bk && g <= bk + 6) ? 1 : 0);
    end
    rst_b = 1'b1;
    for (int c = 0; c < 1500 && exp_q.size() > 0; c++) begin
      @(negedge core_clk);
    end
    if (exp_q.size() > 0) chk("drain", 0, exp_q.size());
    $display("test done split %0d slow %0d idle %0d", sp, sl, in);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========
  // sequence and watchdog
  initial begin
    run(1'b1, 1'b0, 255, 0, 255, 40);
    run(1'b1, 1'b1, 255, 0, 255, 40);
    for (int n = 2; n <= 5; n++) run(1'b0, 1'b0, 3, n, 255, 10);
    run(1'b0, 1'b0, 255, 0, 4, 14);
    end_sim();
  end
  initial begin
    #40000;
    n_errors++;
    end_sim();
  end
endmodule // vdc_dispatch_stall_control_test

bind vdc_dispatch_stall_control vdc_assertions #(
  .GROUP_WORDS(GROUP_WORDS), .WORD_BITS(WORD_BITS)) chk_i (.core_clk,
  .rst_b, .pmem_req, .pmem_addr, .pmem_ready, .dmem_req, .dmem_ready,
  .e1_is_load, .e1_is_branch, .e1_branch_target, .e1_idle_count,
  .issue_valid, .decode_valid, .exec_later_valid, .load_writeback,
  .dispatch_stall, .memory_stall, .idle_active);
